// ### verilog/async_serial_transmitter.sv
// Asynchronous serial transmitter with Avalon-MM register slave
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Transmitter runs only with transmit enable set, sync clear, port enable set.
// - Port enable alone turns the serial output pin driver on.
// - Buffer empty flag is set the cycle after the transmitter becomes active.
// - Idle output rests at mark level with default polarity.
// - Frame is start space, eight or nine data bits, stop mark.
// - Every frame bit lasts exactly one baud period.
// - Data bits leave least significant bit first.
// - Uses shared character format and baud settings, independent of receiver.
// - Baud divider from system clock, eight or sixteen bits wide.
// - Holding buffer write starts sending; idle shifter loads it immediately.
// - Pending character waits for stop bit, then transfers within one cycle.
// - Start bit begins right after transfer into the shift register.
// - Polarity bit resets to zero; set inverts idle and data levels.
// - Polarity inversion applies only in asynchronous mode.
// - No hardware parity; ninth bit carries software parity.
// - Serial output goes to pin and to logic cell and modulator outputs.
// - Buffer empty flag read-only; clear while transmitter inactive or while busy with one waiting.
// - Shifter empty set while idle; clear from transfer until all bits out.
// - Nine-bit mode sends ninth bit last; software writes ninth bit first.
// - Buffer empty flag shows new state from third cycle after write.
module async_serial_transmitter (
	input  wire logic        MCLK,
	input  wire logic        RST_B,
	input  wire logic        CLK_EN,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             SERIAL_OUT,
	output logic             SERIAL_OUT_OE,
	output logic             CLC_TX_OUT,
	output logic             DSM_TX_OUT,
	output logic             TX_BUFFER_EMPTY_FLAG
);
	logic [6:0]             ctrl_r;
	logic [15:0]            div_r;
	logic [8:0]             hold_r;
	logic                   hold_full_r;
	logic [9:0]             shift_r;
	logic [3:0]             bits_left_r;
	logic [15:0]            baud_cnt_r;
	async_tx_pkg::tx_state_t state_r;
	logic                   flag_r;
	logic                   flag_dly_r;
	logic                   ack_r;
	logic [31:0]            rdata_r;
	logic                   out_r;

	wire transmit_enable_bit    = ctrl_r[async_tx_pkg::CTRL_TRANSMIT_ENABLE_BIT_POS];
	wire sync_mode              = ctrl_r[async_tx_pkg::CTRL_SYNC_POS];
	wire serial_port_enable     = ctrl_r[async_tx_pkg::CTRL_SERIAL_PORT_ENABLE_POS];
	wire nine_bit_select        = ctrl_r[async_tx_pkg::CTRL_NINE_POS];
	wire ninth_data_bit         = ctrl_r[async_tx_pkg::CTRL_NINTH_POS];
	wire output_polarity_invert = ctrl_r[async_tx_pkg::CTRL_INV_POS];
	wire wide_divider           = ctrl_r[async_tx_pkg::CTRL_WIDE_POS];

	wire tx_active = transmit_enable_bit & ~sync_mode & serial_port_enable;
	// Same compare serves the write strobes and the read mux
	function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	wire req       = AVS_READ | AVS_WRITE;
	// First edge only latches read data; writes land when waitrequest is low
	wire access    = req & ~ack_r & CLK_EN;
	wire commit    = req & ack_r & CLK_EN;
	wire wr_ctrl   = commit & AVS_WRITE & addr_hit(AVS_ADDRESS, async_tx_pkg::CTRL_OFFSET) & AVS_BYTEENABLE[0];
	wire wr_data   = commit & AVS_WRITE & addr_hit(AVS_ADDRESS, async_tx_pkg::DATA_OFFSET) & AVS_BYTEENABLE[0];
	wire wr_div_lo = commit & AVS_WRITE & addr_hit(AVS_ADDRESS, async_tx_pkg::DIV_OFFSET) & AVS_BYTEENABLE[0];
	wire wr_div_hi = commit & AVS_WRITE & addr_hit(AVS_ADDRESS, async_tx_pkg::DIV_OFFSET) & AVS_BYTEENABLE[1];

	// Narrow divider ignores the high byte
	wire [15:0] div_eff = wide_divider ? div_r : {8'h00, div_r[7:0]};
	wire        baud_tick = (baud_cnt_r == div_eff);
	wire        shifter_empty_status = (state_r == async_tx_pkg::ST_IDLE);
	wire        shifting = (state_r == async_tx_pkg::ST_SHIFT);
	wire        last_bit = shifting & baud_tick & (bits_left_r == 4'h1);
	// Load when idle, or in the same cycle the stop bit finishes
	wire        load = tx_active & hold_full_r & (shifter_empty_status | last_bit);
	// Start bit in LSB; eight-bit word carries its stop mark, nine-bit stop shifts in behind the data; no parity generator
	wire [9:0]  frame_word = nine_bit_select ? {hold_r, 1'b0} : {1'b1, hold_r[7:0], 1'b0};
	wire [3:0]  frame_len = nine_bit_select ? 4'hb : 4'ha;
	wire        flag_now = tx_active & ~(hold_full_r & ~shifter_empty_status & ~last_bit);
	wire        line_level = shifting ? shift_r[0] : 1'b1;
	wire        tx_level = line_level ^ (output_polarity_invert & ~sync_mode);

	wire [31:0] status_word = {30'h0, shifter_empty_status, flag_r};
	wire [31:0] rd_mux =
		addr_hit(AVS_ADDRESS, async_tx_pkg::CTRL_OFFSET)   ? {25'h0, ctrl_r} :
		addr_hit(AVS_ADDRESS, async_tx_pkg::DATA_OFFSET)   ? {23'h0, hold_r} :
		addr_hit(AVS_ADDRESS, async_tx_pkg::STATUS_OFFSET) ? status_word :
		addr_hit(AVS_ADDRESS, async_tx_pkg::DIV_OFFSET)    ? {16'h0, div_r} : 32'h0;

	assign AVS_WAITREQUEST      = req & ~(ack_r & CLK_EN);
	assign AVS_READDATA         = rdata_r;
	assign SERIAL_OUT           = out_r;
	assign SERIAL_OUT_OE        = serial_port_enable;
	assign CLC_TX_OUT           = out_r;
	assign DSM_TX_OUT           = out_r;
	assign TX_BUFFER_EMPTY_FLAG = flag_r;

	// One-cycle acknowledge: answer in the cycle after the request is seen
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0;
		end else if (CLK_EN) begin
			ack_r   <= access;
			if (access && AVS_READ)
				rdata_r <= rd_mux;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_r <= async_tx_pkg::CTRL_RESET;
			div_r  <= async_tx_pkg::DIV_RESET;
		end else if (CLK_EN) begin
			if (wr_ctrl)
				ctrl_r <= AVS_WRITEDATA[6:0];
			if (wr_div_lo)
				div_r[7:0] <= AVS_WRITEDATA[7:0];
			if (wr_div_hi)
				div_r[15:8] <= AVS_WRITEDATA[15:8];
		end
	end

	// Holding buffer; ninth bit sampled at the data write
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			hold_r      <= 9'h000;
			hold_full_r <= 1'b0;
		end else if (CLK_EN) begin
			if (!tx_active)
				hold_full_r <= 1'b0;
			else if (wr_data) begin
				hold_r      <= {ninth_data_bit, AVS_WRITEDATA[7:0]};
				hold_full_r <= 1'b1;
			end else if (load)
				hold_full_r <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			state_r     <= async_tx_pkg::ST_IDLE;
			shift_r     <= 10'h3ff;
			bits_left_r <= 4'h0;
			baud_cnt_r  <= 16'h0000;
		end else if (CLK_EN) begin
			case (state_r)
				async_tx_pkg::ST_IDLE: begin
					baud_cnt_r <= 16'h0000;
					if (load) begin
						shift_r     <= frame_word;
						bits_left_r <= frame_len;
						state_r     <= async_tx_pkg::ST_SHIFT;
					end
				end
				async_tx_pkg::ST_SHIFT: begin
					if (!tx_active)
						state_r <= async_tx_pkg::ST_IDLE;
					else if (baud_tick) begin
						baud_cnt_r <= 16'h0000;
						if (load) begin
							shift_r     <= frame_word;
							bits_left_r <= frame_len;
						end else if (last_bit)
							state_r <= async_tx_pkg::ST_IDLE;
						else begin
							shift_r     <= {1'b1, shift_r[9:1]};
							bits_left_r <= bits_left_r - 4'h1;
						end
					end else
						baud_cnt_r <= baud_cnt_r + 16'h0001;
				end
				default: state_r <= async_tx_pkg::ST_IDLE;
			endcase
		end
	end

	// Flag holds its old value for two cycles after a data write
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			flag_r     <= 1'b0;
			flag_dly_r <= 1'b0;
			out_r      <= 1'b1;
		end else if (CLK_EN) begin
			flag_dly_r <= wr_data;
			if (!(wr_data | flag_dly_r) || !tx_active)
				flag_r <= flag_now;
			out_r <= tx_level;
		end
	end

	a_flag_delay: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && wr_data && tx_active) |=> (flag_r == $past(flag_r)))
		else $error("buffer empty flag changed right after write");
	a_idle_mark: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && shifter_empty_status && !output_polarity_invert) |=> (!CLK_EN || out_r))
		else $error("idle line not at mark");
	a_start_bit: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && load) |=> (shift_r[0] == 1'b0))
		else $error("frame does not begin with start bit");
	a_oe_follows: assert property (@(posedge MCLK) disable iff (!RST_B)
		SERIAL_OUT_OE == serial_port_enable)
		else $error("pin driver not tied to port enable");
	a_abort_empty: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && !tx_active) |=> (!hold_full_r))
		else $error("holding buffer not emptied on disable");
	a_inactive_idle: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && !tx_active && shifter_empty_status) |=> shifter_empty_status)
		else $error("shifter started while disabled");
	a_bit_period: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && shifting && !baud_tick && tx_active) |=> (bits_left_r == $past(bits_left_r)))
		else $error("bit advanced before baud tick");
	a_inv_level: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && shifter_empty_status && output_polarity_invert && !sync_mode) |=> (!CLK_EN || !out_r))
		else $error("inverted idle not at low level");
	a_flag_set_empty: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && tx_active && !hold_full_r && !wr_data && !flag_dly_r)
		|=> flag_r)
		else $error("buffer empty flag not set with buffer empty");
	a_flag_clear_busy: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && tx_active && hold_full_r && shifting && !last_bit && !wr_data && !flag_dly_r)
		|=> !flag_r)
		else $error("buffer empty flag set while character waits");
	a_flag_off_disabled: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && !tx_active)
		|=> !flag_r)
		else $error("buffer empty flag set while disabled");
	a_shifter_busy_load: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && load)
		|=> !shifter_empty_status)
		else $error("shifter empty status not cleared on transfer");
	a_stop_to_idle: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && tx_active && last_bit && !load)
		|=> shifter_empty_status)
		else $error("shifter not idle after last stop bit");
	a_stop_bit_mark: assert property (@(posedge MCLK) disable iff (!RST_B)
		(shifting && (bits_left_r == 4'h1))
		|-> shift_r[0])
		else $error("stop bit not at mark level");
	a_lsb_shift: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && tx_active && shifting && baud_tick && !last_bit)
		|=> (shift_r[9] && ((shift_r << 1) == ($past(shift_r) & 10'h3fe))))
		else $error("shift register did not move toward LSB");
	a_bit_hold: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && tx_active && shifting && !baud_tick)
		|=> $stable(shift_r))
		else $error("line bit changed inside a baud period");
	a_len_eight: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && load && !nine_bit_select)
		|=> (bits_left_r == 4'ha))
		else $error("eight-bit frame length wrong");
	a_len_nine: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && load && nine_bit_select)
		|=> (bits_left_r == 4'hb))
		else $error("nine-bit frame length wrong");
	a_data_eight: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && load && !nine_bit_select)
		|=> (shift_r[9] && ({1'b0, shift_r[8:1]} == ($past(hold_r) & 9'h0ff))))
		else $error("eight-bit frame word wrong");
	a_data_nine: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && load && nine_bit_select)
		|=> (shift_r[9:1] == $past(hold_r)))
		else $error("nine-bit frame word wrong");
	a_sync_halts: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && sync_mode)
		|=> shifter_empty_status)
		else $error("shifter running in clocked mode");
	a_sync_no_invert: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && sync_mode && shifter_empty_status)
		|=> (!CLK_EN || out_r))
		else $error("polarity inversion applied in clocked mode");
	a_enable_freeze: assert property (@(posedge MCLK) disable iff (!RST_B)
		!CLK_EN
		|=> ($stable(state_r) && $stable(shift_r) && $stable(out_r) && $stable(flag_r)))
		else $error("state moved while clock enable low");
	a_one_wait: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && req && !ack_r)
		|=> (!req || !CLK_EN || !AVS_WAITREQUEST))
		else $error("waitrequest held past one wait cycle");
	a_ack_drops: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && commit)
		|=> !ack_r)
		else $error("acknowledge not released after transfer");
	a_ctrl_write: assert property (@(posedge MCLK) disable iff (!RST_B)
		wr_ctrl
		|=> ({25'h0, ctrl_r} == ($past(AVS_WRITEDATA) & 32'h0000007f)))
		else $error("control write did not land");
	a_tick_restart: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && tx_active && shifting && baud_tick)
		|=> (baud_cnt_r == 16'h0000))
		else $error("baud counter not restarted at bit end");
	a_idle_stays: assert property (@(posedge MCLK) disable iff (!RST_B)
		(CLK_EN && shifter_empty_status && !load)
		|=> shifter_empty_status)
		else $error("shifter left idle without a load");
endmodule
`default_nettype wire

// ### common/async_tx_pkg.sv
// Constants for the asynchronous serial transmitter
package async_tx_pkg;
	// Register word offsets (byte addresses)
	localparam logic [3:0] CTRL_OFFSET   = 4'h0;
	localparam logic [3:0] DATA_OFFSET   = 4'h4;
	localparam logic [3:0] STATUS_OFFSET = 4'h8;
	localparam logic [3:0] DIV_OFFSET    = 4'hc;
	// Control register field positions
	localparam int CTRL_TRANSMIT_ENABLE_BIT_POS  = 0;
	localparam int CTRL_SYNC_POS  = 1;
	localparam int CTRL_SERIAL_PORT_ENABLE_POS  = 2;
	localparam int CTRL_NINE_POS  = 3;
	localparam int CTRL_NINTH_POS = 4;
	localparam int CTRL_INV_POS   = 5;
	localparam int CTRL_WIDE_POS  = 6;
	// Status register field positions
	localparam int STAT_TX_BUFFER_EMPTY_FLAG_POS  = 0;
	localparam int STAT_SHIFTER_EMPTY_STATUS_POS  = 1;
	// Reset values
	localparam logic [6:0]  CTRL_RESET = 7'h00;
	localparam logic [15:0] DIV_RESET  = 16'h0000;
	// Flag update delay after a holding-buffer write, in cycles
	localparam int FLAG_DELAY_CYCLES = 2;
	// Frame bits: start, up to nine data, stop
	localparam int FRAME_BITS_MAX = 11;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01
	} tx_state_t;
endpackage

// ### verification/serial_rx_model.sv
// Far-end receiver model that decodes the serial line
`timescale 1ns/1ps
`default_nettype none
module serial_rx_model (
	input  wire logic        clk,
	input  wire logic        line,
	input  wire logic        inv,
	input  wire logic        nine,
	input  wire logic [15:0] period,
	output logic      [8:0]  data,
	output logic             stop_ok,
	output int               count
);
	logic lv;
	assign lv = line ^ inv;
	// Mid-bit sampling exposes a wrong bit length within two bits
	initial begin
		data = 9'h000;
		stop_ok = 1'b0;
		count = 0;
		forever begin
			@(posedge clk);
			if (lv === 1'b0) begin
				repeat (period / 2) @(posedge clk);
				if (lv === 1'b0) begin
					data = 9'h000;
					for (int i = 0; i < (nine ? 9 : 8); i++) begin
						repeat (period) @(posedge clk);
						data[i] = lv;
					end
					repeat (period) @(posedge clk);
					stop_ok = lv;
					count++;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### verification/async_serial_transmitter_test.sv
// Self-checking bench for the asynchronous serial transmitter
`timescale 1ns/1ps
`default_nettype none
module async_serial_transmitter_test;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, q;
	logic        wreq, ser, oe, configurable_logic_cell, signal_modulator, flag, rx_stop;
	logic        inv_m = 1'b0;
	logic        nine_m = 1'b0;
	logic        clk_en = 1'b1;
	logic [8:0]  rx_data;
	int          rx_count;
	int          num_errors = 0;
	int          checks_done = 0;
	always #5 mclk = ~mclk;
	async_serial_transmitter dut (.MCLK(mclk), .RST_B(rst_b), .CLK_EN(clk_en), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
		.SERIAL_OUT(ser), .SERIAL_OUT_OE(oe), .CLC_TX_OUT(configurable_logic_cell), .DSM_TX_OUT(signal_modulator), .TX_BUFFER_EMPTY_FLAG(flag));
	serial_rx_model rx (.clk(mclk), .line(ser), .inv(inv_m), .nine(nine_m), .period(16'h0004), .data(rx_data),
		.stop_ok(rx_stop), .count(rx_count));
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Request stands until waitrequest is seen low at a rising edge
	task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
		int i;
		addr <= a;
		wdata <= d;
		rd <= r;
		wr <= !r;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (wreq !== 1'b0 && i < 50);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge mclk);
		if (i >= 50) begin
			num_errors++;
			summarize();
		end
	endtask
	task automatic wait_rx(input int n);
		for (int i = 0; i < 3000 && rx_count < n; i++)
			@(posedge mclk);
		if (rx_count < n) begin
			num_errors++;
			summarize();
		end
	endtask
	task automatic sc_reset();
		chk(32'({ser, oe, flag}), 32'h4);
		bus(1'b1, 4'h0, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, 4'h1, 32'h0);
		chk(q, 32'h0);
	endtask
	task automatic sc_enable();
		bus(1'b0, 4'hc, 32'h3);
		bus(1'b0, 4'h0, 32'h4);
		chk(32'({oe, flag}), 32'h2);
		bus(1'b0, 4'h4, 32'h5a);
		bus(1'b0, 4'h0, 32'h7);
		bus(1'b0, 4'h4, 32'h5a);
		bus(1'b0, 4'h0, 32'h5);
		@(posedge mclk);
		chk(32'(flag), 32'h1);
		repeat (60) @(posedge mclk);
		chk(32'(rx_count), 32'h0);
	endtask
	task automatic sc_b2b();
		bus(1'b0, 4'h4, 32'ha5);
		bus(1'b0, 4'h4, 32'h3c);
		repeat (2) @(posedge mclk);
		chk(32'(flag), 32'h0);
		wait_rx(1);
		chk(32'({rx_stop, rx_data}), 32'h2a5);
		wait_rx(2);
		chk(32'({rx_stop, rx_data}), 32'h23c);
		repeat (8) @(posedge mclk);
		chk(32'({ser, configurable_logic_cell, signal_modulator}), 32'h7);
		bus(1'b1, 4'h8, 32'h0);
		chk(q & 32'h3, 32'h3);
	endtask
	task automatic sc_nine();
		nine_m <= 1'b1;
		bus(1'b0, 4'h0, 32'h1d);
		bus(1'b0, 4'h4, 32'h55);
		wait_rx(3);
		chk(32'(rx_data), 32'h155);
		nine_m <= 1'b0;
	endtask
	task automatic sc_invert();
		bus(1'b0, 4'h0, 32'h25);
		inv_m <= 1'b1;
		@(posedge mclk);
		chk(32'(ser), 32'h0);
		bus(1'b0, 4'h4, 32'h0f);
		wait_rx(4);
		chk(32'(rx_data), 32'h00f);
		bus(1'b0, 4'h0, 32'h05);
		inv_m <= 1'b0;
	endtask
	task automatic sc_abort();
		logic s;
		bus(1'b0, 4'h4, 32'h55);
		repeat (10) @(posedge mclk);
		// Alternating bits make any movement during the freeze visible
		clk_en <= 1'b0;
		@(posedge mclk);
		s = ser;
		repeat (8) @(posedge mclk);
		chk(32'(ser), 32'(s));
		clk_en <= 1'b1;
		bus(1'b0, 4'h0, 32'h04);
		repeat (2) @(posedge mclk);
		chk(32'(ser), 32'h1);
		bus(1'b1, 4'h8, 32'h0);
		chk(q & 32'h3, 32'h2);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		sc_reset();
		sc_enable();
		sc_b2b();
		sc_nine();
		sc_invert();
		sc_abort();
		summarize();
	end
endmodule
`default_nettype wire
